// ==== cjcrs_core.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] read-state request 0x46/0x2F, address 1..247, echoed plus one state byte
// [R2] state byte: 0x00 stopped, 0x01 started, 0x02 refresh once
// [R3] write-state 0x46/0x30, new state in byte 3; reply echoes plus result
// [R4] written 0x02 fires one refresh; 0x00/0x01 stop or start continuous refresh
// [R5] unservable compensation request answered with 0xC6 and exception code
// [R6] node address zero at power-on: software config mode, load stored settings
// [R7] in software config mode switch settings are ignored
// [R8] in software config mode config and range commands change stored settings
// [R9] host watchdog expiry drives all outputs to their safe state
// [R10] module watchdog resets the module when operation stalls
// [R11] reset flag set at power-on and on every module watchdog reset
// [R12] reset flag reported by reset-flag read, cleared only after that reply
// [R13] after any module reset digital outputs take their power-on values
// [R14] host watchdog counter restarted by each valid request; limit configurable
module cjcrs_core #(
	parameter int MOD_WDT_CYCLES = cjcrs_pkg::MOD_WDT_CYCLES,
	parameter int DOUT_W = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire cjcrs_pkg::cjcrs_req_t req,
	input wire cjcrs_pkg::cjcrs_cfg_t switch_cfg,
	input wire cjcrs_pkg::cjcrs_cfg_t stored_cfg,
	input wire logic core_alive,
	input wire logic host_wdt_en,
	input wire logic [cjcrs_pkg::CNT_W-1:0] host_wdt_limit,
	input wire logic dout_wr_valid,
	input wire logic [DOUT_W-1:0] dout_wr_data,
	input wire logic [DOUT_W-1:0] dout_poweron,
	input wire logic [DOUT_W-1:0] dout_safe,
	output logic rsp_valid,
	output cjcrs_pkg::cjcrs_rsp_t rsp,
	output cjcrs_pkg::cjcrs_cfg_t active_cfg,
	output logic sw_config_mode,
	output logic stored_wr,
	output cjcrs_pkg::cjcrs_cfg_t stored_wr_cfg,
	output logic [7:0] refresh_state,
	output logic refresh_run,
	output logic refresh_once,
	output logic safe_state,
	output logic [DOUT_W-1:0] dout,
	output logic reset_flag,
	output logic module_reset
);

	cjcrs_pkg::cjcrs_state_t state, next_state;
	logic next_rsp_valid, next_sw_config_mode, next_stored_wr, next_refresh_run;
	logic next_refresh_once, next_safe_state, next_reset_flag, next_module_reset;
	cjcrs_pkg::cjcrs_rsp_t next_rsp;
	cjcrs_pkg::cjcrs_cfg_t next_active_cfg, next_stored_wr_cfg;
	logic [7:0] next_refresh_state;
	logic [DOUT_W-1:0] next_dout;
	logic [cjcrs_pkg::CNT_W-1:0] host_cnt, next_host_cnt, mod_cnt, next_mod_cnt;
	logic addr_hit, host_expire, mod_expire;

	// request addressed to this node, and watchdog expiry terms
	assign addr_hit = req_valid && (state == cjcrs_pkg::ST_RUN) && (req.addr == active_cfg.addr)
		&& (req.addr >= cjcrs_pkg::ADDR_MIN) && (req.addr <= cjcrs_pkg::ADDR_MAX); // R1
	assign host_expire = host_wdt_en && !safe_state && (host_cnt >= host_wdt_limit); // R14
	assign mod_expire = (mod_cnt == MOD_WDT_CYCLES[cjcrs_pkg::CNT_W-1:0] - 1'b1); // R10

	// next-state logic for the whole command and supervision path
	always_comb
	begin
		next_state = state;
		next_rsp_valid = 1'b0;
		next_rsp = rsp;
		next_active_cfg = active_cfg;
		next_sw_config_mode = sw_config_mode;
		next_stored_wr = 1'b0;
		next_stored_wr_cfg = stored_wr_cfg;
		next_refresh_state = refresh_state;
		next_refresh_run = refresh_run;
		next_refresh_once = 1'b0;
		next_safe_state = safe_state;
		next_dout = dout;
		next_reset_flag = reset_flag;
		next_module_reset = 1'b0;
		next_host_cnt = host_wdt_en ? host_cnt + 1'b1 : '0;
		next_mod_cnt = core_alive ? '0 : mod_cnt + 1'b1;
		if (state == cjcrs_pkg::ST_BOOT)
		begin
			// power-on strap decides the configuration source
			next_state = cjcrs_pkg::ST_RUN;
			next_dout = dout_poweron; // R13
			if (switch_cfg.addr == cjcrs_pkg::ADDR_SW_CONFIG)
			begin
				next_sw_config_mode = 1'b1; // R6
				next_active_cfg = stored_cfg; // R6
			end
			else
			begin
				next_sw_config_mode = 1'b0;
				next_active_cfg = switch_cfg;
			end
		end
		else
		begin
			// switches follow live only outside software config mode
			if (!sw_config_mode)
				next_active_cfg = switch_cfg; // R7
			if (dout_wr_valid)
				next_dout = dout_wr_data;
			if (addr_hit)
			begin
				next_host_cnt = '0; // R14
				next_safe_state = 1'b0;
				next_rsp.addr = req.addr;
				next_rsp.func = req.func;
				next_rsp.b2 = req.sub;
				next_rsp.b3 = cjcrs_pkg::RESULT_OK;
				next_rsp.len = cjcrs_pkg::LEN_REPLY;
				unique case (req.kind)
					cjcrs_pkg::KIND_MODBUS:
					begin
						next_rsp_valid = (req.func == cjcrs_pkg::FUNC_COMP);
						if (req.sub == cjcrs_pkg::SUB_READ_STATE)
							next_rsp.b3 = refresh_state; // R1 R2
						else if (req.sub == cjcrs_pkg::SUB_WRITE_STATE
							&& req.arg <= cjcrs_pkg::STATE_ONCE)
						begin
							next_refresh_state = req.arg; // R3
							next_refresh_run = (req.arg == cjcrs_pkg::STATE_STARTED); // R4
							next_refresh_once = (req.arg == cjcrs_pkg::STATE_ONCE); // R4
						end
						else
						begin
							// exception frame: address, 0xC6, code
							next_rsp.func = cjcrs_pkg::FUNC_EXC; // R5
							next_rsp.b2 = (req.sub == cjcrs_pkg::SUB_WRITE_STATE)
								? cjcrs_pkg::EXC_ILLEGAL_VALUE : cjcrs_pkg::EXC_ILLEGAL_FUNC; // R5
							next_rsp.b3 = cjcrs_pkg::BYTE_ZERO;
							next_rsp.len = cjcrs_pkg::LEN_EXC;
						end
					end
					cjcrs_pkg::KIND_RST_READ:
					begin
						next_rsp_valid = 1'b1;
						next_rsp.b3 = {7'h00, reset_flag}; // R12
						next_reset_flag = 1'b0; // R12
					end
					cjcrs_pkg::KIND_MOD_CFG:
					begin
						next_rsp_valid = 1'b1;
						next_rsp.b3 = sw_config_mode ? cjcrs_pkg::RESULT_OK : cjcrs_pkg::RESULT_FAIL;
						if (sw_config_mode)
						begin
							next_active_cfg.addr = req.cfg_addr; // R8
							next_active_cfg.format = req.cfg_format; // R8
							next_stored_wr = 1'b1;
							next_stored_wr_cfg = next_active_cfg;
						end
					end
					cjcrs_pkg::KIND_CH_RANGE:
					begin
						next_rsp_valid = 1'b1;
						next_rsp.b3 = sw_config_mode ? cjcrs_pkg::RESULT_OK : cjcrs_pkg::RESULT_FAIL;
						if (sw_config_mode)
						begin
							next_active_cfg.type_code = req.cfg_type; // R8
							next_stored_wr = 1'b1;
							next_stored_wr_cfg = next_active_cfg;
						end
					end
				endcase
			end
			else if (host_expire)
			begin
				// lost host: force outputs safe
				next_safe_state = 1'b1; // R9
				next_dout = dout_safe; // R9
			end
			if (mod_expire)
			begin
				// stalled module: reset it; flag set wins over a same-cycle clear
				next_module_reset = 1'b1; // R10
				next_mod_cnt = '0;
				next_reset_flag = 1'b1; // R11
				next_dout = dout_poweron; // R13
				next_safe_state = 1'b0;
				next_host_cnt = '0;
				next_refresh_state = cjcrs_pkg::STATE_STOPPED;
				next_refresh_run = 1'b0;
				next_refresh_once = 1'b0;
				next_rsp_valid = 1'b0;
			end
		end
	end

	// state registers; power-on sets the reset flag
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= cjcrs_pkg::ST_BOOT;
			rsp_valid <= 1'b0;
			rsp <= '0;
			active_cfg <= '0;
			sw_config_mode <= 1'b0;
			stored_wr <= 1'b0;
			stored_wr_cfg <= '0;
			refresh_state <= cjcrs_pkg::STATE_STOPPED;
			refresh_run <= 1'b0;
			refresh_once <= 1'b0;
			safe_state <= 1'b0;
			dout <= '0;
			reset_flag <= 1'b1; // R11
			module_reset <= 1'b0;
			host_cnt <= '0;
			mod_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			rsp_valid <= next_rsp_valid;
			rsp <= next_rsp;
			active_cfg <= next_active_cfg;
			sw_config_mode <= next_sw_config_mode;
			stored_wr <= next_stored_wr;
			stored_wr_cfg <= next_stored_wr_cfg;
			refresh_state <= next_refresh_state;
			refresh_run <= next_refresh_run;
			refresh_once <= next_refresh_once;
			safe_state <= next_safe_state;
			dout <= next_dout;
			reset_flag <= next_reset_flag;
			module_reset <= next_module_reset;
			host_cnt <= next_host_cnt;
			mod_cnt <= next_mod_cnt;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_read_state_reply: assert property ( // R1
		addr_hit && req.kind == cjcrs_pkg::KIND_MODBUS && req.func == cjcrs_pkg::FUNC_COMP
		&& req.sub == cjcrs_pkg::SUB_READ_STATE && !mod_expire
		|=> rsp_valid && rsp.func == cjcrs_pkg::FUNC_COMP && rsp.b2 == cjcrs_pkg::SUB_READ_STATE
		&& rsp.b3 == $past(refresh_state) && rsp.len == cjcrs_pkg::LEN_REPLY)
		else $error("read-state reply wrong");
	chk_state_code_run: assert property ( // R2
		refresh_run |-> refresh_state == cjcrs_pkg::STATE_STARTED)
		else $error("run flag disagrees with state code");
	chk_write_result_ok: assert property ( // R3
		addr_hit && req.kind == cjcrs_pkg::KIND_MODBUS && req.func == cjcrs_pkg::FUNC_COMP
		&& req.sub == cjcrs_pkg::SUB_WRITE_STATE && req.arg <= cjcrs_pkg::STATE_ONCE && !mod_expire
		|=> rsp_valid && rsp.b3 == cjcrs_pkg::RESULT_OK && refresh_state == $past(req.arg))
		else $error("write-state not applied");
	chk_once_single_pulse: assert property ( // R4
		refresh_once |=> !refresh_once)
		else $error("single refresh pulse held");
	chk_exception_frame: assert property ( // R5
		addr_hit && req.kind == cjcrs_pkg::KIND_MODBUS && req.func == cjcrs_pkg::FUNC_COMP
		&& req.sub != cjcrs_pkg::SUB_READ_STATE && req.sub != cjcrs_pkg::SUB_WRITE_STATE && !mod_expire
		|=> rsp_valid && rsp.func == cjcrs_pkg::FUNC_EXC && rsp.b2 == cjcrs_pkg::EXC_ILLEGAL_FUNC)
		else $error("exception frame missing");
	chk_boot_sw_mode: assert property ( // R6
		state == cjcrs_pkg::ST_BOOT && switch_cfg.addr == cjcrs_pkg::ADDR_SW_CONFIG
		|=> sw_config_mode && active_cfg == $past(stored_cfg))
		else $error("software config mode not entered");
	chk_switch_ignored: assert property ( // R7
		sw_config_mode && state == cjcrs_pkg::ST_RUN && !addr_hit
		|=> active_cfg == $past(active_cfg))
		else $error("switches changed config in software mode");
	chk_host_safe: assert property ( // R9
		host_expire && !addr_hit && !mod_expire && state == cjcrs_pkg::ST_RUN
		|=> safe_state && dout == $past(dout_safe))
		else $error("safe state not forced");
	chk_module_reset: assert property ( // R11
		mod_expire && state == cjcrs_pkg::ST_RUN
		|=> module_reset && reset_flag && dout == $past(dout_poweron) ##1 !module_reset)
		else $error("module reset effects missing");
	chk_flag_report: assert property ( // R12
		addr_hit && req.kind == cjcrs_pkg::KIND_RST_READ && !mod_expire
		|=> rsp_valid && rsp.b3[0] == $past(reset_flag) && !reset_flag)
		else $error("reset flag report or clear wrong");
	chk_host_restart: assert property ( // R14
		addr_hit && !mod_expire |=> host_cnt == '0)
		else $error("host watchdog not restarted");

endmodule : cjcrs_core

`default_nettype wire

// ==== cjcrs_pkg.sv ====
package cjcrs_pkg;

	// request framing
	localparam logic [7:0] FUNC_COMP = 8'h46;
	localparam logic [7:0] FUNC_EXC = 8'hc6;
	localparam logic [7:0] SUB_READ_STATE = 8'h2f;
	localparam logic [7:0] SUB_WRITE_STATE = 8'h30;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [7:0] ADDR_SW_CONFIG = 8'h00;

	// refresh state codes
	localparam logic [7:0] STATE_STOPPED = 8'h00;
	localparam logic [7:0] STATE_STARTED = 8'h01;
	localparam logic [7:0] STATE_ONCE = 8'h02;

	// result and exception codes
	localparam logic [7:0] RESULT_OK = 8'h00;
	localparam logic [7:0] RESULT_FAIL = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [2:0] LEN_EXC = 3'h3;
	localparam logic [2:0] LEN_REPLY = 3'h4;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int MOD_WDT_TIME_US = 1000;
	localparam int MOD_WDT_CYCLES = MOD_WDT_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 32;

	typedef enum logic [1:0] {
		KIND_MODBUS = 2'b00,
		KIND_RST_READ = 2'b01,
		KIND_MOD_CFG = 2'b10,
		KIND_CH_RANGE = 2'b11
	} cjcrs_kind_t;

	typedef enum logic {
		ST_BOOT = 1'b0,
		ST_RUN = 1'b1
	} cjcrs_state_t;

	typedef struct packed {
		cjcrs_kind_t kind;
		logic [7:0] addr;
		logic [7:0] func;
		logic [7:0] sub;
		logic [7:0] arg;
		logic [7:0] cfg_addr;
		logic [7:0] cfg_format;
		logic [7:0] cfg_type;
	} cjcrs_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] func;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [2:0] len;
	} cjcrs_rsp_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] format;
		logic [7:0] type_code;
	} cjcrs_cfg_t;

endpackage : cjcrs_pkg

// ==== cjcrs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host model: one request at a time, reply sampled just after the taking edge
module cjcrs_host (
	input wire logic core_clk,
	input wire logic rsp_valid,
	input wire cjcrs_pkg::cjcrs_rsp_t rsp,
	output logic req_valid,
	output cjcrs_pkg::cjcrs_req_t req
);
	logic got;
	cjcrs_pkg::cjcrs_rsp_t seen;
	// idle values at time zero
	initial
	begin
		req_valid = 1'b0;
		req = '0;
		got = 1'b0;
		seen = '0;
	end
	// framed request, then released fields toggle, then reply sampled
	task automatic send(input logic [1:0] k, input logic [7:0] a, input logic [7:0] s,
		input logic [7:0] g);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{cjcrs_pkg::cjcrs_kind_t'(k), a, cjcrs_pkg::FUNC_COMP, s, g, g, g, g};
		@(posedge core_clk);
		req_valid <= 1'b0;
		req <= ~req;
		#1;
		got = rsp_valid; // reply strobe stands only until the next edge
		seen = rsp;
	endtask : send
endmodule : cjcrs_host
`default_nettype wire

// ==== cjcrs_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cjcrs_core_tb;
	logic core_clk, arst_n, core_alive, host_wdt_en, dout_wr_valid, hb_en, req_valid;
	logic rsp_valid, sw_config_mode, stored_wr, refresh_run, refresh_once;
	logic safe_state, reset_flag, module_reset;
	logic [31:0] host_wdt_limit;
	logic [7:0] dout_wr_data, dout, refresh_state, adr;
	cjcrs_pkg::cjcrs_req_t req;
	cjcrs_pkg::cjcrs_rsp_t rsp;
	cjcrs_pkg::cjcrs_cfg_t switch_cfg, stored_cfg, active_cfg, stored_wr_cfg;
	int n_errors, checks, cyc, n;

	cjcrs_core #(.MOD_WDT_CYCLES(16), .DOUT_W(8)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.req_valid(req_valid), .req(req), .switch_cfg(switch_cfg), .stored_cfg(stored_cfg),
		.core_alive(core_alive), .host_wdt_en(host_wdt_en), .host_wdt_limit(host_wdt_limit),
		.dout_wr_valid(dout_wr_valid), .dout_wr_data(dout_wr_data), .dout_poweron(8'h3c),
		.dout_safe(8'hc3), .rsp_valid(rsp_valid), .rsp(rsp), .active_cfg(active_cfg),
		.sw_config_mode(sw_config_mode), .stored_wr(stored_wr), .stored_wr_cfg(stored_wr_cfg),
		.refresh_state(refresh_state), .refresh_run(refresh_run), .refresh_once(refresh_once),
		.safe_state(safe_state), .dout(dout), .reset_flag(reset_flag), .module_reset(module_reset));
	cjcrs_host host (.core_clk(core_clk), .rsp_valid(rsp_valid), .rsp(rsp),
		.req_valid(req_valid), .req(req));

	// clock generator
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// heartbeat and hang limit
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		core_alive <= hb_en & (cyc[1:0] == 2'h0);
		if (cyc == 4000)
		begin
			n_errors++;
			give_verdict;
		end
	end

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// reply fields; data byte only on full replies
	task automatic reply(input logic [7:0] f, input logic [7:0] b2, input logic [7:0] b3,
		input logic [2:0] len);
		check(host.got, 1'b1);
		check({host.seen.addr, host.seen.func, host.seen.b2, host.seen.len}, {adr, f, b2, len});
		if (len == 3'h4)
			check(host.seen.b3, b3);
	endtask : reply
	task automatic do_reset;
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : do_reset
	task automatic t_state;
		host.send(2'h0, adr, 8'h2f, 8'h00);
		reply(8'h46, 8'h2f, 8'h00, 3'h4);
		for (int v = 0; v < 3; v++)
		begin
			host.send(2'h0, adr, 8'h30, v[7:0]);
			reply(8'h46, 8'h30, 8'h00, 3'h4);
			check(refresh_state, v[7:0]);
			check(refresh_run, v == 1);
			check(refresh_once, v == 2);
			host.send(2'h0, adr, 8'h2f, 8'h00);
			check(host.seen.b3, v[7:0]);
		end
		$display("state test done");
	endtask : t_state
	task automatic t_errors;
		host.send(2'h0, adr, 8'h2b, 8'h00);
		reply(8'hc6, 8'h01, 8'h00, 3'h3);
		host.send(2'h0, adr, 8'h30, 8'h03);
		reply(8'hc6, 8'h03, 8'h00, 3'h3);
		check(refresh_state, 8'h02);
		host.send(2'h0, 8'h06, 8'h2f, 8'h00);
		check(host.got, 1'b0);
		host.send(2'h2, adr, 8'h00, 8'h44);
		reply(8'h46, 8'h00, 8'h01, 3'h4);
		host.send(2'h1, adr, 8'h00, 8'h00);
		reply(8'h46, 8'h00, 8'h01, 3'h4);
		host.send(2'h1, adr, 8'h00, 8'h00);
		reply(8'h46, 8'h00, 8'h00, 3'h4);
		check(reset_flag, 1'b0);
		$display("error and flag test done");
	endtask : t_errors
	task automatic t_wdt;
		@(posedge core_clk);
		dout_wr_valid <= 1'b1;
		host_wdt_limit <= 32'h14;
		host_wdt_en <= 1'b1;
		@(posedge core_clk);
		dout_wr_valid <= 1'b0;
		for (n = 0; n < 60 && safe_state !== 1'b1; n++)
		begin
			@(posedge core_clk);
			#1;
		end
		check(n >= 18 && n <= 24, 1'b1);
		check({safe_state, dout}, {1'b1, 8'hc3});
		host.send(2'h0, adr, 8'h2f, 8'h00);
		check(safe_state, 1'b0);
		@(posedge core_clk);
		host_wdt_en <= 1'b0;
		hb_en <= 1'b0;
		for (n = 0; n < 40 && module_reset !== 1'b1; n++)
		begin
			@(posedge core_clk);
			#1;
		end
		check(n >= 10 && n <= 20, 1'b1);
		check({reset_flag, dout}, {1'b1, 8'h3c});
		hb_en <= 1'b1;
		$display("watchdog test done");
	endtask : t_wdt
	task automatic t_sw;
		@(posedge core_clk);
		switch_cfg <= '{8'h00, 8'h01, 8'h02};
		do_reset;
		check({sw_config_mode, active_cfg, dout}, {1'b1, stored_cfg, 8'h3c});
		@(posedge core_clk);
		switch_cfg <= '{8'h09, 8'h01, 8'h02};
		repeat (3) @(posedge core_clk);
		#1;
		check(active_cfg, stored_cfg);
		adr = 8'h21;
		host.send(2'h2, adr, 8'h00, 8'h33);
		reply(8'h46, 8'h00, 8'h00, 3'h4);
		check({stored_wr, stored_wr_cfg.addr, active_cfg.addr}, {1'b1, 8'h33, 8'h33});
		adr = 8'h33;
		host.send(2'h3, adr, 8'h00, 8'h07);
		reply(8'h46, 8'h00, 8'h00, 3'h4);
		check({stored_wr, active_cfg.type_code, active_cfg.format}, {1'b1, 8'h07, 8'h33});
		$display("config mode test done");
	endtask : t_sw
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// main sequence
	initial
	begin
		{arst_n, core_alive, host_wdt_en, dout_wr_valid, n_errors, checks, cyc} = '0;
		hb_en = 1'b1;
		host_wdt_limit = 32'h0;
		dout_wr_data = 8'h5a;
		adr = 8'h05;
		switch_cfg = '{8'h05, 8'h01, 8'h02};
		stored_cfg = '{8'h21, 8'h04, 8'h05};
		do_reset;
		check({reset_flag, dout, sw_config_mode}, {1'b1, 8'h3c, 1'b0});
		t_state;
		t_errors;
		t_wdt;
		t_sw;
		give_verdict;
	end
endmodule : cjcrs_core_tb
`default_nettype wire
